// File: tcp_chk.sv
// Link checks between the controller end and the port device end
`timescale 1ns/1ns
module tcp_chk (
   input wire logic hclk, // System clock
   input wire logic hresetn, // Reset, active low
   input wire logic scl, // Clock wire
   input wire logic sda, // Data wire
   input wire logic sda_oe_d, // Device pulls data low
   input wire logic irq_oe // Device pulls interrupt low
);
   logic scl_q, sda_q, frame_q;
   wire start_w = scl & scl_q & sda_q & ~sda;
   wire stop_w = scl & scl_q & ~sda_q & sda;
   wire frame_d = start_w | (frame_q & ~stop_w);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         frame_q <= 1'b0;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         frame_q <= frame_d;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_start;
      start_w;
   endsequence
   sequence s_stop;
      stop_w;
   endsequence
   sequence s_quiet;
      !sda_oe_d [*8];
   endsequence
   property p_start_quiet;
      s_start |-> scl [*8] and s_quiet;
   endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("start not clean");
   property p_dev_chg;
      $changed(sda_oe_d) |-> !scl;
   endproperty
   a_dev_chg: assert property (p_dev_chg) else $error("data moved with clock high");
   property p_dev_hold;
      $rose(scl) |-> $stable(sda_oe_d) [*8];
   endproperty
   a_dev_hold: assert property (p_dev_hold) else $error("data unstable in high");
   property p_dev_idle;
      !frame_q |-> !sda_oe_d;
   endproperty
   a_dev_idle: assert property (p_dev_idle) else $error("device drives idle bus");
   property p_ack_len;
      $rose(sda_oe_d) |-> sda_oe_d [*8];
   endproperty
   a_ack_len: assert property (p_ack_len) else $error("device bit too short");
   property p_stop_rel;
      s_stop |=> s_quiet;
   endproperty
   a_stop_rel: assert property (p_stop_rel) else $error("data held after stop");
   property p_irq_hold;
      $rose(irq_oe) |-> irq_oe [*8];
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt pulse too short");
   property p_irq_rel;
      $fell(irq_oe) |-> frame_q;
   endproperty
   a_irq_rel: assert property (p_irq_rel) else $error("interrupt freed outside frame");
endmodule

// File: tcp_dev.sv
// Port device end: bus target, registers, interrupt and role logic
//
// Our own choice: the AHB-Lite interface to the controller end's command registers.
`timescale 1ns/1ns
module tcp_dev #(
   parameter int DRP_CYC = tcp_pkg::DRP_CYC_DEF,
   parameter logic [7:0] DEV_ID = tcp_pkg::DEV_ID_DEF
) (
   input wire logic hclk,             // System clock
   input wire logic hresetn,          // Power-on reset, active low
   tcp_if.dev bus,                    // Bus and interrupt wires
   input wire logic chip_disable_n,   // Chip disable, low enables
   input wire logic addr_float,       // Address-select pin floating
   input wire logic addr_level,       // Address-select pin level when tied
   input wire logic [1:0] role_strap, // Port-role strap level
   input wire logic cc_attached,      // Connection detected on lines
   input wire logic [1:0] cc_cap,     // Detected host charging capability
   input wire logic accessory,        // Audio or debug accessory seen
   input wire logic vconn_ocp,        // Supply over-current limit hit
   output logic attach_ind_oe,        // Attach indicator pin pulled low
   output logic src_en,               // Current sources on both lines
   output logic [1:0] src_level,      // Advertised current level
   output logic sink_pulldown_a,      // Sink pull-down on line A
   output logic sink_pulldown_b       // Sink pull-down on line B
);
   import tcp_pkg::*;
   localparam int NI = 10;
   localparam int TW = $clog2(DRP_CYC + 1);
   logic [NI-1:0] raw, s1_q, s2_q, s3_q, st_q;
   logic [1:0] ln_raw, l1_q, l2_q, l3_q, lf_q, lp_q;
   logic [1:0] lcnt_q [2];
   logic en_p_q, att_q, acc_q, ocp_q, host_pres_q;
   logic [2:0] init_q;
   logic [7:0] ctrl_q, flags_q, stat_q, sh_q;
   logic [2:0] ptr_q;
   logic [3:0] cnt_q;
   logic rw_q, nack_q, sda_oe_q, irq_oe_q;
   logic src_en_q, ind_q, pd_q;
   logic [1:0] lvl_q;
   logic [TW-1:0] tog_q;
   tcp_dst_t st;

   assign raw = {chip_disable_n, addr_float, addr_level, role_strap, cc_attached,
                 cc_cap, accessory, vconn_ocp};
   assign ln_raw = {bus.sda, bus.scl};

   // A level counts once the second and third stages agree
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         st_q <= '0;
      end else begin
         s1_q <= raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (s3_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q));
      end
   end

   wire en = ~st_q[9];
   wire pin_mode = st_q[8];
   wire addr_hi = st_q[7];
   wire [1:0] strap = st_q[6:5];
   wire att_in = st_q[4] & en;
   wire [1:0] cap = st_q[3:2];
   wire acc_in = st_q[1];
   wire ocp_in = st_q[0];

   // spike filter
   // A change must stand for FILT_CYC agreeing samples to pass
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_line
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               l1_q[g] <= 1'b1;
               l2_q[g] <= 1'b1;
               l3_q[g] <= 1'b1;
               lf_q[g] <= 1'b1;
               lp_q[g] <= 1'b1;
               lcnt_q[g] <= '0;
            end else begin
               l1_q[g] <= ln_raw[g];
               l2_q[g] <= l1_q[g];
               l3_q[g] <= l2_q[g];
               lp_q[g] <= lf_q[g];
               if (l2_q[g] != l3_q[g] || l3_q[g] == lf_q[g]) begin
                  lcnt_q[g] <= '0;
               end else if (lcnt_q[g] == 2'(FILT_CYC - 1)) begin
                  lf_q[g] <= l3_q[g];
                  lcnt_q[g] <= '0;
               end else begin
                  lcnt_q[g] <= lcnt_q[g] + 2'h1;
               end
            end
         end
      end
   endgenerate

   wire scl_f = lf_q[0];
   wire sda_f = lf_q[1];
   wire scl_rise = scl_f & ~lp_q[0];
   wire scl_fall = ~scl_f & lp_q[0];
   wire start_c = scl_f & lp_q[0] & lp_q[1] & ~sda_f;
   wire stop_c = scl_f & lp_q[0] & ~lp_q[1] & sda_f;
   wire bus_rst = en_p_q ^ en;
   // pin control leaves the bus untouched
   wire bus_off = bus_rst | pin_mode;
   wire [1:0] role = ctrl_q[ROLE_HI:ROLE_LO];
   // select pin steers one address bit
   wire [6:0] my_addr = TGT_BASE | (7'(addr_hi) << SEL_BIT);

   // reads walk from register one upward
   function automatic logic [7:0] rd_sel(input logic [2:0] idx);
      if (idx == IDX_ID) rd_sel = DEV_ID;
      else if (idx == IDX_CTRL) rd_sel = ctrl_q;
      else if (idx == IDX_INT) rd_sel = flags_q;
      else if (idx == IDX_STAT) rd_sel = stat_q;
      else rd_sel = 8'h00;
   endfunction

   wire [7:0] rd_byte = rd_sel(ptr_q);
   wire ld = scl_fall & ~bus_off & ~start_c & ~stop_c &
             ((st == D_AACK && rw_q) || (st == D_RACK && !nack_q));
   // a read of the flag register clears it
   wire rd_clr = ld & (ptr_q == IDX_INT);
   // only the second written byte lands in control
   wire wr_ctrl = scl_fall & ~bus_off & ~start_c & ~stop_c & (st == D_WR) &
                  (cnt_q == BYTE_BITS) & (ptr_q == IDX_CTRL);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= D_IDLE;
         cnt_q <= '0;
         sh_q <= '0;
         ptr_q <= IDX_ID;
         rw_q <= 1'b0;
         nack_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else if (bus_off || stop_c) begin
         st <= D_IDLE;
         sda_oe_q <= 1'b0;
      end else if (start_c) begin
         st <= D_ADDR;
         cnt_q <= '0;
         ptr_q <= IDX_ID;
         sda_oe_q <= 1'b0;
      end else if (ld) begin
         sh_q <= rd_byte;
         sda_oe_q <= ~rd_byte[7];
         cnt_q <= 4'h1;
         ptr_q <= ptr_q + 3'h1;
         st <= D_RD;
      end else begin
         case (st)
            D_ADDR, D_WR: begin
               if (scl_rise) begin
                  sh_q <= {sh_q[6:0], sda_f};
                  cnt_q <= cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BYTE_BITS) begin
                  if (st == D_WR) begin
                     sda_oe_q <= 1'b1;
                     ptr_q <= ptr_q + 3'h1;
                     st <= D_WACK;
                  end else if (sh_q[7:1] == my_addr) begin
                     sda_oe_q <= 1'b1;
                     rw_q <= sh_q[0];
                     st <= D_AACK;
                  end else begin
                     st <= D_IDLE;
                  end
               end
            end
            D_AACK, D_WACK: begin
               if (scl_fall) begin
                  sda_oe_q <= 1'b0;
                  cnt_q <= '0;
                  st <= D_WR;
               end
            end
            D_RD: begin
               if (scl_fall) begin
                  if (cnt_q == BYTE_BITS) begin
                     sda_oe_q <= 1'b0;
                     st <= D_RACK;
                  end else begin
                     sda_oe_q <= ~sh_q[6];
                     sh_q <= {sh_q[6:0], 1'b0};
                     cnt_q <= cnt_q + 4'h1;
                  end
               end
            end
            D_RACK: begin
               if (scl_rise) begin
                  nack_q <= sda_f;
               end else if (scl_fall) begin
                  st <= D_IDLE;
               end
            end
            default: begin
               st <= st;
            end
         endcase
      end
   end

   // strap caught once the synchroniser has settled
   // later writes to the role field take over
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= CTRL_RST;
         init_q <= '0;
      end else if (init_q != STRAP_WAIT) begin
         // Strap level is valid only after four edges through the synchroniser
         init_q <= init_q + 3'h1;
         if (init_q + 3'h1 == STRAP_WAIT) begin
            ctrl_q[ROLE_HI:ROLE_LO] <= strap;
         end
      end else if (wr_ctrl) begin
         ctrl_q <= sh_q;
      end
   end

   // dual role alternates presentation until attached
   wire tog_end = tog_q == TW'(DRP_CYC - 1);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tog_q <= '0;
         host_pres_q <= 1'b0;
      end else begin
         tog_q <= (role != ROLE_DUAL || att_q || tog_end) ? '0 : tog_q + TW'(1);
         if (role == ROLE_HOST) host_pres_q <= 1'b1;
         else if (role != ROLE_DUAL) host_pres_q <= 1'b0;
         else if (tog_end && !att_q) host_pres_q <= ~host_pres_q;
      end
   end

   // attach and detach edges, fault edge, status change
   wire [7:0] stat_d = {3'h0, acc_in, host_pres_q, att_in, host_pres_q ? 2'h0 : cap};
   wire [7:0] ev = {4'h0, stat_d != stat_q, ocp_in & ~ocp_q, ~att_in & att_q,
                    att_in & ~att_q};
   wire [7:0] set = ctrl_q[CTRL_MASK] ? 8'h00 : ev;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_p_q <= 1'b1;
         att_q <= 1'b0;
         acc_q <= 1'b0;
         ocp_q <= 1'b0;
         stat_q <= '0;
         flags_q <= '0;
      end else begin
         en_p_q <= en;
         // connection forced to disabled on a disable edge
         att_q <= att_in & ~bus_rst;
         acc_q <= acc_in;
         ocp_q <= ocp_in;
         // capability shown while presenting as sink
         stat_q <= stat_d;
         // Set wins over a clearing read in the same cycle
         flags_q <= (flags_q & ~{8{rd_clr}}) | set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_oe_q <= 1'b0;
         src_en_q <= 1'b0;
         lvl_q <= '0;
         pd_q <= 1'b1;
         ind_q <= 1'b0;
      end else begin
         // pending flags pull the line, unless masked
         irq_oe_q <= en & ~ctrl_q[CTRL_MASK] & (|flags_q);
         src_en_q <= en & host_pres_q;
         lvl_q <= ctrl_q[CUR_HI:CUR_LO];
         pd_q <= ~en | ~host_pres_q;
         // indicator on attach, not for accessories
         ind_q <= en & host_pres_q & att_q & ~acc_q;
      end
   end

   assign bus.sda_oe_d = sda_oe_q;
   assign bus.irq_oe = irq_oe_q;
   assign attach_ind_oe = ind_q;
   assign src_en = src_en_q;
   assign src_level = lvl_q;
   assign sink_pulldown_a = pd_q;
   assign sink_pulldown_b = pd_q;
endmodule

// File: tcp_host.sv
// Controller end: bus-mapped command registers driving a two-wire master
`timescale 1ns/1ns
module tcp_host #(
   parameter logic [6:0] TGT_ADDR = tcp_pkg::TGT_BASE,
   parameter int QTR = tcp_pkg::QTR_CYC
) (
   input wire logic hclk,           // System clock
   input wire logic hresetn,        // Reset, active low
   input wire logic hsel,           // Slave select
   input wire logic [31:0] haddr,   // Byte address
   input wire logic [1:0] htrans,   // Transfer type
   input wire logic hwrite,         // Write when high
   input wire logic [2:0] hsize,    // Transfer size, word only
   input wire logic [31:0] hwdata,  // Write data
   input wire logic hready,         // Bus ready
   output logic [31:0] hrdata,      // Read data
   output logic hreadyout,          // Slave ready
   output logic hresp,              // Response, always okay
   tcp_if.ctl bus                   // Bus and interrupt wires
);
   import tcp_pkg::*;
   localparam int QW = $clog2(QTR + 1);
   logic [1:0] s1_q, s2_q, s3_q, st_q;
   logic [31:0] wdata_q, rdata_q, hrdata_q;
   logic [2:0] nby_q, byte_q;
   logic rd_q, busy_q, nack_q, go_q, aw_q, scl_oe_q, sda_oe_q, rdy_q;
   logic [7:0] aa_q;
   logic [QW-1:0] qc_q;
   logic [1:0] ph_q;
   logic [3:0] bit_q;
   tcp_hst_t hs;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q <= 2'h3;
         s2_q <= 2'h3;
         s3_q <= 2'h3;
         st_q <= 2'h3;
      end else begin
         s1_q <= {bus.irq_n_out, bus.sda};
         s2_q <= s1_q;
         s3_q <= s2_q;
         st_q <= (s3_q & ~(s2_q ^ s3_q)) | (st_q & (s2_q ^ s3_q));
      end
   end
   wire sda_in = st_q[0];
   wire irq_pend = ~st_q[1];

   // Zero-wait slave: read data registered in the address phase
   wire a_ok = hsel & hready & htrans[1];
   wire [7:0] a8 = haddr[7:0];
   wire [31:0] rmux = (a8 == OFF_WDATA) ? wdata_q :
                      (a8 == OFF_RDATA) ? rdata_q :
                      (a8 == OFF_STAT) ? {29'h0, irq_pend, nack_q, busy_q} : 32'h0;
   wire wr_cmd = aw_q & (aa_q == OFF_CMD) & ~busy_q;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aw_q <= 1'b0;
         aa_q <= '0;
         hrdata_q <= '0;
         rdy_q <= 1'b1;
         wdata_q <= '0;
         nby_q <= '0;
         rd_q <= 1'b0;
      end else begin
         aw_q <= a_ok & hwrite;
         aa_q <= a8;
         if (a_ok && !hwrite) hrdata_q <= rmux;
         if (aw_q && aa_q == OFF_WDATA) wdata_q <= hwdata;
         if (wr_cmd) begin
            nby_q <= hwdata[2:0];
            rd_q <= hwdata[CMD_RD];
         end
      end
   end

   wire tick = qc_q == QW'(QTR - 1);
   wire last = byte_q == nby_q;
   // every transfer starts at register one, bytes in order
   // write byte k goes to register k
   wire [7:0] txb = (byte_q == 3'h0) ? {TGT_ADDR, rd_q} : wdata_q[8*(byte_q-3'h1) +: 8];
   wire ack_bit = bit_q == BYTE_BITS;
   wire rx_data = rd_q & (byte_q != 3'h0);
   wire drv = ack_bit ? (rx_data & ~last) : (~rx_data & ~txb[3'h7 - bit_q[2:0]]);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hs <= H_IDLE;
         go_q <= 1'b0;
         qc_q <= '0;
         ph_q <= '0;
         bit_q <= '0;
         byte_q <= '0;
         busy_q <= 1'b0;
         nack_q <= 1'b0;
         rdata_q <= '0;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
      end else begin
         qc_q <= (hs == H_IDLE || tick) ? '0 : qc_q + QW'(1);
         if (tick && hs != H_IDLE) ph_q <= ph_q + 2'h1;
         if (wr_cmd) begin
            busy_q <= 1'b1;
            nack_q <= 1'b0;
            hs <= H_START;
            ph_q <= '0;
         end else if (tick) begin
            case (hs)
               H_START: begin
                  if (ph_q == 2'h1) sda_oe_q <= 1'b1;
                  if (ph_q == 2'h2) scl_oe_q <= 1'b1;
                  if (ph_q == 2'h3) begin
                     hs <= H_BIT;
                     bit_q <= '0;
                     byte_q <= '0;
                  end
               end
               H_BIT: begin
                  if (ph_q == 2'h0) sda_oe_q <= drv;
                  if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                  if (ph_q == 2'h2 && !ack_bit && rx_data) rdata_q <= {rdata_q[30:0], sda_in};
                  if (ph_q == 2'h2 && ack_bit && !rx_data) nack_q <= sda_in;
                  if (ph_q == 2'h3) begin
                     scl_oe_q <= 1'b1;
                     bit_q <= ack_bit ? 4'h0 : bit_q + 4'h1;
                     if (ack_bit) byte_q <= byte_q + 3'h1;
                     if (ack_bit && (last || nack_q)) hs <= H_STOP;
                  end
               end
               H_STOP: begin
                  if (ph_q == 2'h0) sda_oe_q <= 1'b1;
                  if (ph_q == 2'h1) scl_oe_q <= 1'b0;
                  if (ph_q == 2'h2) sda_oe_q <= 1'b0;
                  if (ph_q == 2'h3) begin
                     hs <= H_IDLE;
                     busy_q <= 1'b0;
                  end
               end
               default: begin
                  hs <= H_IDLE;
               end
            endcase
         end
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = rdy_q;
   assign hresp = 1'b0;
   assign bus.scl_oe = scl_oe_q;
   assign bus.sda_oe_h = sda_oe_q;
endmodule

// File: tcp_if.sv
// Two-wire bus and interrupt line joining controller and port device
`timescale 1ns/1ns
interface tcp_if;
   logic scl_oe;
   logic sda_oe_h;
   logic sda_oe_d;
   logic irq_oe;
   logic scl;
   logic sda;
   logic irq_n_out;
   // Pulled-up open-drain wires
   assign scl = ~scl_oe;
   assign sda = ~(sda_oe_h | sda_oe_d);
   assign irq_n_out = ~irq_oe;
   modport dev (input scl, input sda, output sda_oe_d, output irq_oe);
   modport ctl (output scl_oe, output sda_oe_h, input sda, input irq_n_out);
endinterface

// File: tcp_pkg.sv
// Shared constants, register map and state types for the port controller link
// Notes on behaviour
// - Address bit five follows address-select pin level.
// - Floating select pin means pin control mode.
// - No offset byte; reads run from register one.
// - Writes also run sequentially from register one.
// - Interrupt output low on flag or status change.
// - Reading interrupt register clears flags, releases output.
// - Flags report attach and detach events.
// - Mask bit set keeps interrupt released, events ignored.
// - Reset initialises registers and bus state machine.
// - Role field loaded from strap at reset release.
// - Software may rewrite role field; device follows.
// - Host role enables current sources on both lines.
// - Device role connects both sink pull-downs.
// - Dual role toggles every 50 ms until attached.
// - Host current level selectable by control register.
// - Detected charging capability shown in status register.
// - Host presentation pulls attach indicator on attach.
// - Controller reads flags then status after interrupt.
// - Bus inputs ignore glitches up to 50 ns.
// - Chip-disable edges reset bus and connection state.
// - Indicator released in device role and for accessories.
// - Over-current fault drives interrupt output low.
package tcp_pkg;
   localparam int CLK_NS = 20;
   localparam int SPIKE_NS = 50;
   localparam int FILT_CYC = (SPIKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int TOGGLE_MS = 50;
   localparam int DRP_CYC_DEF = TOGGLE_MS * 1000000 / CLK_NS;
   localparam int T_LOW_NS = 1300;
   localparam int QTR_CYC = (T_LOW_NS / 2 + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] STRAP_WAIT = 3'h5;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic [6:0] TGT_BASE = 7'h0d;
   localparam int SEL_BIT = 5;
   // Identity byte value is arbitrary
   localparam logic [7:0] DEV_ID_DEF = 8'h5a;
   localparam logic [2:0] IDX_ID = 3'h1;
   localparam logic [2:0] IDX_CTRL = 3'h2;
   localparam logic [2:0] IDX_INT = 3'h3;
   localparam logic [2:0] IDX_STAT = 3'h4;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam int CTRL_MASK = 0;
   localparam int ROLE_LO = 1;
   localparam int ROLE_HI = 2;
   localparam int CUR_LO = 3;
   localparam int CUR_HI = 4;
   localparam logic [1:0] ROLE_DEV = 2'h0;
   localparam logic [1:0] ROLE_HOST = 2'h1;
   localparam logic [1:0] ROLE_DUAL = 2'h2;
   localparam int FL_ATT = 0;
   localparam int FL_DET = 1;
   localparam int FL_OCP = 2;
   localparam int FL_STAT = 3;
   localparam logic [7:0] OFF_CMD = 8'h00;
   localparam logic [7:0] OFF_WDATA = 8'h04;
   localparam logic [7:0] OFF_RDATA = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0c;
   localparam int CMD_RD = 8;
   typedef enum {D_IDLE, D_ADDR, D_AACK, D_WR, D_WACK, D_RD, D_RACK} tcp_dst_t;
   typedef enum {H_IDLE, H_START, H_BIT, H_STOP} tcp_hst_t;
endpackage

// File: typec_port_i2c_control_tb_top.sv
// Bench joining controller and device ends over the two-wire link
`timescale 1ns/1ns
module typec_port_i2c_control_tb_top;
   import tcp_pkg::*;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, prev_en;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd, st;
   logic [1:0] htrans = 2'h0, role_strap = ROLE_DUAL, cc_cap = 2'h0, src_level;
   logic chip_disable_n = 1'b0, addr_float = 1'b0, addr_level = 1'b0, cc_attached = 1'b0;
   logic accessory = 1'b0, vconn_ocp = 1'b0, hreadyout, attach_ind_oe, src_en;
   logic sink_pulldown_a, sink_pulldown_b;
   int miscompares = 0, comparisons = 0, cyc = 0, n = 0;
   // Control byte, expected source enable, expected pull-downs
   logic [9:0] rows [4] = '{{8'h03, 2'b10}, {8'h0b, 2'b10}, {8'h13, 2'b10}, {8'h01, 2'b01}};
   tcp_if u_tcp_if ();
   tcp_host #(.QTR(16)) u_tcp_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .bus(u_tcp_if.ctl));
   // Short toggle period keeps the dual-role run brief
   tcp_dev #(.DRP_CYC(200)) u_tcp_dev (.hclk(hclk), .hresetn(hresetn), .bus(u_tcp_if.dev),
      .chip_disable_n(chip_disable_n), .addr_float(addr_float), .addr_level(addr_level),
      .role_strap(role_strap), .cc_attached(cc_attached), .cc_cap(cc_cap),
      .accessory(accessory), .vconn_ocp(vconn_ocp), .attach_ind_oe(attach_ind_oe),
      .src_en(src_en), .src_level(src_level), .sink_pulldown_a(sink_pulldown_a),
      .sink_pulldown_b(sink_pulldown_b));
   tcp_chk u_tcp_chk (.hclk(hclk), .hresetn(hresetn), .scl(u_tcp_if.scl), .sda(u_tcp_if.sda),
      .sda_oe_d(u_tcp_if.sda_oe_d), .irq_oe(u_tcp_if.irq_oe));
   initial forever #10 hclk = ~hclk;
   task automatic finish_test();
      if (miscompares == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         miscompares = miscompares + 1;
         finish_test();
      end
   end
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic ahb(logic wr, logic [7:0] a, logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // Whole link transfer; busy polling is cut short only by the cycle ceiling
   task automatic xfer(logic [31:0] cmd, logic [31:0] wd);
      ahb(1'b1, OFF_WDATA, wd);
      ahb(1'b1, OFF_CMD, cmd);
      st = 32'h1;
      while (st[0] !== 1'b0) begin
         ahb(1'b0, OFF_STAT, 32'h0);
         st = rd;
      end
      ahb(1'b0, OFF_RDATA, 32'h0);
   endtask
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (8) @(negedge hclk);
      prev_en = src_en;
      repeat (1000) begin
         @(negedge hclk);
         if (src_en !== prev_en) n++;
         prev_en = src_en;
      end
      check("toggles", n >= 4 && n <= 6, 1);
      xfer(32'h102, 32'h0);
      check("strap_ctrl", rd[15:0], {DEV_ID_DEF, 5'h0, ROLE_DUAL, 1'b0});
      for (int i = 0; i < 4; i++) begin
         xfer(32'h2, {16'h0, rows[i][9:2], 8'h00});
         check("src_en", src_en, rows[i][1]);
         check("pulldowns", {sink_pulldown_a, sink_pulldown_b}, {2{rows[i][0]}});
         if (rows[i][1]) check("level", src_level, rows[i][6:5]);
      end
      for (int i = 0; i < 3; i++) begin
         addr_level <= (i == 1);
         addr_float <= (i == 2);
         repeat (8) @(posedge hclk);
         xfer(32'h0, 32'h0);
         check("nack", st[1], i > 0);
      end
      addr_float <= 1'b0;
      xfer(32'h2, 32'h0200);
      xfer(32'h104, 32'h0);
      check("irq_idle", u_tcp_if.irq_n_out, 1);
      cc_attached <= 1'b1;
      repeat (10) @(posedge hclk);
      check("irq_attach", u_tcp_if.irq_n_out, 0);
      check("ind_attach", attach_ind_oe, 1);
      xfer(32'h104, 32'h0);
      check("flags_status", {rd[8], rd[3:0]}, 5'h1c);
      check("irq_clear", u_tcp_if.irq_n_out, 1);
      cc_attached <= 1'b0;
      repeat (10) @(posedge hclk);
      xfer(32'h103, 32'h0);
      check("flag_detach", rd[1], 1);
      xfer(32'h2, 32'h0300);
      cc_attached <= 1'b1;
      accessory <= 1'b1;
      repeat (10) @(posedge hclk);
      check("irq_masked", u_tcp_if.irq_n_out, 1);
      check("ind_accessory", attach_ind_oe, 0);
      accessory <= 1'b0;
      xfer(32'h2, 32'h0200);
      repeat (10) @(posedge hclk);
      check("irq_unmasked", u_tcp_if.irq_n_out, 1);
      cc_cap <= 2'h2;
      xfer(32'h2, 32'h0100);
      xfer(32'h104, 32'h0);
      check("cap", rd[1:0], 2'h2);
      check("ind_device", attach_ind_oe, 0);
      chip_disable_n <= 1'b1;
      repeat (10) @(posedge hclk);
      check("disabled", {src_en, sink_pulldown_a, sink_pulldown_b, attach_ind_oe}, 4'h6);
      chip_disable_n <= 1'b0;
      repeat (10) @(posedge hclk);
      xfer(32'h102, 32'h0);
      check("ctrl_kept", rd[7:0], 8'h01);
      xfer(32'h2, 32'h0000);
      vconn_ocp <= 1'b1;
      repeat (10) @(posedge hclk);
      check("irq_ocp", u_tcp_if.irq_n_out, 0);
      finish_test();
   end
endmodule
